/* common/psr_pkg.sv */
package psr_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [7:0]       IDX_LOCK   = 8'h07;
    localparam logic [7:0]       IDX_ROLE   = 8'h08;
    localparam logic [7:0]       IDX_LEVEL  = 8'h09;
    localparam logic [3:0][7:0]  IDX_SEL    = {8'h0D, 8'h0C, 8'h0B, 8'h0A};
    localparam logic [7:0]       IDX_EXTERNAL_SWITCHING_ENABLE  = 8'h0E;
    localparam logic [7:0]       REG_RESET  = 8'h00;
    localparam logic [1:0]       ROLE_IN    = 2'h0;
    localparam logic [1:0]       ROLE_STAT  = 2'h1;
    localparam logic [1:0]       ROLE_LOW   = 2'h2;
    localparam logic [1:0]       ROLE_HIGH  = 2'h3;
    localparam int               POL_BIT    = 7;
    localparam int               OD_BIT     = 6;
    localparam int               SRC_LSB    = 3;
    localparam logic [2:0]       SRC_BANK_LAST = 3'h4;
    localparam logic [2:0]       SRC_LOCK   = 3'h5;
    localparam logic [2:0]       SRC_LOOP   = 3'h6;
    localparam logic [2:0]       SRC_IRQ    = 3'h7;
    localparam logic [2:0]       LOOP_LOCKED = 3'h4;
    localparam int               LK1_LIVE   = 0;
    localparam int               LK1_LATCH  = 1;
    localparam int               LK1_IE     = 2;
    localparam int               LK2_LIVE   = 4;
    localparam int               LK2_LATCH  = 5;
    localparam int               LK2_IE     = 6;
    localparam logic [7:0]       LOCK_STATUS_MASK = 8'h33;
    localparam logic [39:0]      BANK_IMPL_MASK   = 40'hFFFFFFFFFF;
    localparam logic [1:0]       RESP_OKAY   = 2'h0;
    localparam logic [1:0]       RESP_SLVERR = 2'h2;
    localparam int               SYNC_W     = 6;
endpackage

/* common/psr_pin_if.sv */
`timescale 1ns/10ps
interface psr_pin_if;
    logic [1:0] role;
    logic [7:0] sel;
    logic       level;
    logic       en;
    modport ctl (input role, input sel, output level, output en);
    modport top (output role, output sel, input level, input en);
endinterface

/* rtl/psr_sync.sv */
`timescale 1ns/10ps
module psr_sync (
    input  wire logic                        clk_sys,  // System clock.
    input  wire logic                        reset,    // Synchronous reset.
    input  wire logic [psr_pkg::SYNC_W-1:0]  asyncIn,  // Levels from outside the domain.
    output logic      [psr_pkg::SYNC_W-1:0]  syncOut   // Levels after two flops.
);
    typedef struct packed {
        logic [psr_pkg::SYNC_W-1:0] stage1;
        logic [psr_pkg::SYNC_W-1:0] stage2;
    } psr_sync_s;

    psr_sync_s cur;
    psr_sync_s next_cur;

    // The first stage may go metastable, so only the second stage reads it.
    always_comb begin
        next_cur        = cur;
        next_cur.stage1 = asyncIn;
        next_cur.stage2 = cur.stage1;
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign syncOut = cur.stage2;
endmodule

/* rtl/psr_pin_ctl.sv */
`timescale 1ns/10ps
module psr_pin_ctl (
    psr_pin_if.ctl          pin,         // Role and select in, drive out.
    input  wire logic [39:0] statusBank, // Status registers A0h to A4h.
    input  wire logic [7:0]  lockWord,   // Lock status register image.
    input  wire logic        loopLocked, // Loop state is locked.
    input  wire logic        irqReq      // Device interrupt request.
);
    logic [2:0] srcCode;
    logic [2:0] bitPos;
    logic       srcVal;
    logic       implemented;

    always_comb begin
        srcCode     = pin.sel[psr_pkg::SRC_LSB +: 3];
        bitPos      = pin.sel[2:0];
        srcVal      = 1'b0;
        implemented = 1'b1;
        if (srcCode <= psr_pkg::SRC_BANK_LAST) begin
            srcVal      = statusBank[{srcCode, bitPos}];
            implemented = psr_pkg::BANK_IMPL_MASK[{srcCode, bitPos}];
        end else if (srcCode == psr_pkg::SRC_LOCK) begin
            srcVal      = lockWord[bitPos];
            implemented = psr_pkg::LOCK_STATUS_MASK[bitPos];
        end else if (srcCode == psr_pkg::SRC_LOOP) begin
            srcVal = loopLocked;
        end else begin
            srcVal = irqReq;
        end
        pin.level = 1'b0;
        pin.en    = 1'b0;
        unique case (pin.role)
            psr_pkg::ROLE_IN: begin
                pin.en = 1'b0;
            end
            psr_pkg::ROLE_STAT: begin
                if (!implemented) begin
                    pin.level = 1'b0;
                    pin.en    = 1'b1;
                end else begin
                    pin.level = srcVal ^ pin.sel[psr_pkg::POL_BIT];
                    pin.en    = !pin.sel[psr_pkg::OD_BIT] || srcVal;
                end
            end
            psr_pkg::ROLE_LOW: begin
                pin.en = 1'b1;
            end
            psr_pkg::ROLE_HIGH: begin
                pin.level = 1'b1;
                pin.en    = 1'b1;
            end
        endcase
    end
endmodule

/* rtl/psr_top.sv */
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module psr_top (
    input  wire logic        clk_sys,      // System clock, 20 MHz.
    input  wire logic        reset,        // Synchronous reset, active high.
    input  wire logic [11:0] awaddr,       // Write address.
    input  wire logic        awvalid,      // Write address valid.
    output logic             awready,      // Write address ready.
    input  wire logic [31:0] wdata,        // Write data.
    input  wire logic [3:0]  wstrb,        // Write byte strobes.
    input  wire logic        wvalid,       // Write data valid.
    output logic             wready,       // Write data ready.
    output logic [1:0]       bresp,        // Write response.
    output logic             bvalid,       // Write response valid.
    input  wire logic        bready,       // Write response ready.
    input  wire logic [11:0] araddr,       // Read address.
    input  wire logic        arvalid,      // Read address valid.
    output logic             arready,      // Read address ready.
    output logic [31:0]      rdata,        // Read data.
    output logic [1:0]       rresp,        // Read response.
    output logic             rvalid,       // Read data valid.
    input  wire logic        rready,       // Read data ready.
    input  wire logic [3:0]  pinIn,        // Pad levels of pins one to four.
    output logic      [3:0]  pinOut,       // Pad drive levels.
    output logic      [3:0]  pinOe,        // Pad output enables.
    input  wire logic        mult1LockRaw, // Multiplier one live lock, asynchronous.
    input  wire logic        mult2LockRaw, // Multiplier two live lock, asynchronous.
    input  wire logic [2:0]  loopState,    // Digital loop state field.
    input  wire logic [39:0] statusBank,   // Status registers A0h to A4h.
    input  wire logic        irqOtherIn,   // Other enabled latched status of the device.
    output logic             altSelect,    // Multiplier mux uses its alternate selection.
    output logic             irq           // Level interrupt.
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic            awHave;
        logic [11:0]     awAddr;
        logic            wHave;
        logic [7:0]      wData;
        logic            wLane;
        logic            bValid;
        logic [1:0]      bResp;
        logic            rValid;
        logic [7:0]      rData;
        logic [1:0]      rResp;
        logic [7:0]      roleCfg;
        logic [3:0][7:0] sel;
        logic [1:0]      lockIe;
        logic [1:0]      lockLatch;
        logic [1:0]      lockPrev;
        logic [1:0]      external_switching_enable;
        logic [3:0]      pinOut;
        logic [3:0]      pinOe;
        logic            altSelect;
    } psr_state_s;

    psr_state_s                 cur;
    psr_state_s                 next_cur;
    logic [psr_pkg::SYNC_W-1:0] syncBits;
    logic [3:0]                 pinSync;
    logic                       lk1Sync;
    logic                       lk2Sync;
    logic [7:0]                 lockWord;
    logic                       loopLocked;
    logic                       irqReq;
    logic [3:0]                 pinLevel;
    logic [3:0]                 pinEn;
    logic [1:0]                 lockSet;
    logic [1:0]                 lockClr;

    function automatic logic regHit(input logic [11:0] a, input logic [7:0] idx);
        return a[11:2] == {2'h0, idx};
    endfunction

    function automatic logic isMapped(input logic [11:0] a);
        logic hit;
        hit = regHit(a, psr_pkg::IDX_LOCK) || regHit(a, psr_pkg::IDX_ROLE);
        hit = hit || regHit(a, psr_pkg::IDX_LEVEL) || regHit(a, psr_pkg::IDX_EXTERNAL_SWITCHING_ENABLE);
        for (int i = 0; i < 4; i++) begin
            hit = hit || regHit(a, psr_pkg::IDX_SEL[i]);
        end
        return hit;
    endfunction

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    psr_sync u_sync (
        .clk_sys (clk_sys),
        .reset   (reset),
        .asyncIn ({mult2LockRaw, mult1LockRaw, pinIn}),
        .syncOut (syncBits)
    );

    assign pinSync    = syncBits[3:0];
    assign lk1Sync    = syncBits[4];
    assign lk2Sync    = syncBits[5];
    assign loopLocked = (loopState == psr_pkg::LOOP_LOCKED);

    always_comb begin
        lockWord                     = 8'h00;
        lockWord[psr_pkg::LK1_LIVE]  = lk1Sync;
        lockWord[psr_pkg::LK1_LATCH] = cur.lockLatch[0];
        lockWord[psr_pkg::LK1_IE]    = cur.lockIe[0];
        lockWord[psr_pkg::LK2_LIVE]  = lk2Sync;
        lockWord[psr_pkg::LK2_LATCH] = cur.lockLatch[1];
        lockWord[psr_pkg::LK2_IE]    = cur.lockIe[1];
    end

    assign irq    = |(cur.lockLatch & cur.lockIe);
    assign irqReq = irq || irqOtherIn;

    // ------------------------------------------------------------------
    // Pin controllers
    // ------------------------------------------------------------------
    for (genvar g = 0; g < 4; g++) begin : gPin
        psr_pin_if pinBus ();
        assign pinBus.role = cur.roleCfg[2*g +: 2];
        assign pinBus.sel  = cur.sel[g];
        assign pinLevel[g] = pinBus.level;
        assign pinEn[g]    = pinBus.en;
        psr_pin_ctl u_pin (
            .pin        (pinBus.ctl),
            .statusBank (statusBank),
            .lockWord   (lockWord),
            .loopLocked (loopLocked),
            .irqReq     (irqReq)
        );
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        lockClr  = 2'h0;
        if (awvalid && awready) begin
            next_cur.awHave = 1'b1;
            next_cur.awAddr = awaddr;
        end
        if (wvalid && wready) begin
            next_cur.wHave = 1'b1;
            next_cur.wData = wdata[7:0];
            next_cur.wLane = wstrb[0];
        end
        if (cur.bValid && bready) begin
            next_cur.bValid = 1'b0;
        end
        // Address and data may arrive in either order; the write waits for both.
        if (cur.awHave && cur.wHave) begin
            next_cur.awHave = 1'b0;
            next_cur.wHave  = 1'b0;
            next_cur.bValid = 1'b1;
            next_cur.bResp  = isMapped(cur.awAddr) ? psr_pkg::RESP_OKAY
                                                   : psr_pkg::RESP_SLVERR;
            if (cur.wLane) begin
                if (regHit(cur.awAddr, psr_pkg::IDX_ROLE)) begin
                    next_cur.roleCfg = cur.wData;
                end
                for (int i = 0; i < 4; i++) begin
                    if (regHit(cur.awAddr, psr_pkg::IDX_SEL[i])) begin
                        next_cur.sel[i] = cur.wData;
                    end
                end
                if (regHit(cur.awAddr, psr_pkg::IDX_LOCK)) begin
                    next_cur.lockIe = {cur.wData[psr_pkg::LK2_IE], cur.wData[psr_pkg::LK1_IE]};
                    lockClr = {cur.wData[psr_pkg::LK2_LATCH], cur.wData[psr_pkg::LK1_LATCH]};
                end
                if (regHit(cur.awAddr, psr_pkg::IDX_EXTERNAL_SWITCHING_ENABLE)) begin
                    next_cur.external_switching_enable = cur.wData[1:0];
                end
            end
        end
        // A lock change in the same cycle as its clear keeps the flag set.
        lockSet            = {lk2Sync, lk1Sync} ^ cur.lockPrev;
        next_cur.lockPrev  = {lk2Sync, lk1Sync};
        next_cur.lockLatch = (cur.lockLatch & ~lockClr) | lockSet;

        if (cur.rValid && rready) begin
            next_cur.rValid = 1'b0;
        end
        if (arvalid && arready) begin
            next_cur.rValid = 1'b1;
            next_cur.rResp  = isMapped(araddr) ? psr_pkg::RESP_OKAY : psr_pkg::RESP_SLVERR;
            next_cur.rData  = 8'h00;
            if (regHit(araddr, psr_pkg::IDX_LOCK)) begin
                next_cur.rData = lockWord;
            end
            if (regHit(araddr, psr_pkg::IDX_ROLE)) begin
                next_cur.rData = cur.roleCfg;
            end
            if (regHit(araddr, psr_pkg::IDX_LEVEL)) begin
                next_cur.rData = {4'h0, pinSync};
            end
            if (regHit(araddr, psr_pkg::IDX_EXTERNAL_SWITCHING_ENABLE)) begin
                next_cur.rData = {6'h00, cur.external_switching_enable};
            end
            for (int i = 0; i < 4; i++) begin
                if (regHit(araddr, psr_pkg::IDX_SEL[i])) begin
                    next_cur.rData = cur.sel[i];
                end
            end
        end

        next_cur.pinOut = pinLevel;
        next_cur.pinOe  = pinEn;
        // Pin four becomes the switch-select input and its role field is ignored.
        if (|cur.external_switching_enable) begin
            next_cur.pinOut[3] = 1'b0;
            next_cur.pinOe[3]  = 1'b0;
        end
        next_cur.altSelect = (|cur.external_switching_enable) && pinSync[3];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Ready is refused while a response waits, so at most one write and one read are in flight.
    assign awready   = !cur.awHave && !cur.bValid;
    assign wready    = !cur.wHave && !cur.bValid;
    assign bvalid    = cur.bValid;
    assign bresp     = cur.bResp;
    assign arready   = !cur.rValid;
    assign rvalid    = cur.rValid;
    assign rresp     = cur.rResp;
    assign rdata     = {24'h000000, cur.rData};
    assign pinOut    = cur.pinOut;
    assign pinOe     = cur.pinOe;
    assign altSelect = cur.altSelect;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // Pin outputs are registered, so each pin output property looks one clock after the state behind it.

    chk_role_drive_low: assert property (
        (cur.roleCfg[1:0] == psr_pkg::ROLE_LOW) |=> (!pinOut[0] && pinOe[0]))
        else $error("Pin one not driven low in low role.");

    chk_pin4_switch_in: assert property (
        (|cur.external_switching_enable) |=> (!pinOe[3]) ##1 (!pinOe[3] || !$past(|cur.external_switching_enable)))
        else $error("Pin four driven while external switching is on.");

    chk_pin4_gpio_high: assert property (
        (cur.external_switching_enable == 2'h0 && cur.roleCfg[7:6] == psr_pkg::ROLE_HIGH)
        |=> (pinOut[3] && pinOe[3]))
        else $error("Pin four not general purpose with switching off.");

    chk_level_readback: assert property (
        (arvalid && arready && regHit(araddr, psr_pkg::IDX_LEVEL))
        |=> (rvalid && rdata == {28'h0000000, $past(pinSync)}))
        else $error("Level readback wrong.");

    chk_sync_two_flops: assert property (
        $stable(pinIn) [*3] |-> (pinSync == pinIn))
        else $error("Pin level not synchronised in two cycles.");

    chk_loop_lock_pol: assert property (
        (cur.roleCfg[1:0] == psr_pkg::ROLE_STAT && cur.sel[0][5:3] == psr_pkg::SRC_LOOP
         && !cur.sel[0][psr_pkg::OD_BIT])
        |=> (pinOe[0] && pinOut[0] == ($past(loopLocked) ^ $past(cur.sel[0][7]))))
        else $error("Loop lock status pin wrong.");

    chk_open_drain_off: assert property (
        (cur.roleCfg[1:0] == psr_pkg::ROLE_STAT && cur.sel[0][5:3] == psr_pkg::SRC_LOOP
         && cur.sel[0][psr_pkg::OD_BIT] && !loopLocked) |=> !pinOe[0])
        else $error("Open drain pin driven while inactive.");

    chk_irq_pin_two: assert property (
        (cur.roleCfg[3:2] == psr_pkg::ROLE_STAT && cur.sel[1][6:3] == 4'h7)
        |=> (pinOe[1] && pinOut[1] == ($past(irqReq) ^ $past(cur.sel[1][7]))))
        else $error("Interrupt pin wrong.");

    chk_unimpl_low: assert property (
        (cur.roleCfg[1:0] == psr_pkg::ROLE_STAT && cur.sel[0][5:0] == 6'h2A)
        |=> (!pinOut[0] && pinOe[0]))
        else $error("Unimplemented status bit not driven low.");

    chk_lock_change_latch: assert property (
        (lk1Sync != cur.lockPrev[0]) |=> cur.lockLatch[0] ##1 (irq || !cur.lockIe[0]
        || !cur.lockLatch[0]))
        else $error("Lock change not latched.");

    chk_alt_select: assert property (
        (|cur.external_switching_enable) |=> (altSelect == $past(pinSync[3])))
        else $error("Alternate selection does not follow switch-select.");

    chk_write_resp_hold: assert property (
        (bvalid && !bready) |=> (bvalid && $stable(bresp)))
        else $error("Write response dropped before ready.");

    chk_read_resp_hold: assert property (
        (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
        else $error("Read response changed before ready.");

    chk_bresp_slverr: assert property (
        (cur.awHave && cur.wHave && !isMapped(cur.awAddr))
        |=> (bvalid && bresp == psr_pkg::RESP_SLVERR))
        else $error("Unmapped write not refused.");

    chk_latch_w1c: assert property (
        (lockClr != 2'h0 && lockSet == 2'h0) |=> ((cur.lockLatch & $past(lockClr)) == 2'h0))
        else $error("Latched lock flag not cleared by a written one.");

    chk_role_input_float: assert property (
        (cur.roleCfg[3:2] == psr_pkg::ROLE_IN) |=> !pinOe[1])
        else $error("Input pin two driven.");

    chk_role_drive_high: assert property (
        (cur.roleCfg[5:4] == psr_pkg::ROLE_HIGH) |=> (pinOut[2] && pinOe[2]))
        else $error("Pin three not driven high in high role.");

    chk_alt_select_off: assert property (
        (cur.external_switching_enable == 2'h0) |=> !altSelect)
        else $error("Alternate selection with switching off.");

    chk_bank_follow: assert property (
        (cur.roleCfg[5:4] == psr_pkg::ROLE_STAT && cur.sel[2][5:3] <= psr_pkg::SRC_BANK_LAST
         && cur.sel[2][7:6] == 2'h0)
        |=> (pinOe[2] && pinOut[2] == $past(statusBank[{cur.sel[2][5:3], cur.sel[2][2:0]}])))
        else $error("Pin three does not follow its status bank bit.");

    chk_lock_follow: assert property (
        (cur.roleCfg[1:0] == psr_pkg::ROLE_STAT && cur.sel[0] == 8'h28)
        |=> (pinOe[0] && pinOut[0] == $past(lk1Sync)))
        else $error("Pin one does not follow the live lock flag.");

    cov_role_write: cover property (
        awvalid && awready && wvalid && wready ##1 1'b1 ##1 bvalid && bready);
    cov_switch_mode: cover property ((|cur.external_switching_enable) ##1 altSelect);
    cov_irq_on_pin: cover property (irq ##1 (cur.roleCfg[3:2] == psr_pkg::ROLE_STAT));
    cov_open_drain: cover property (pinOe[0] ##1 !pinOe[0] && cur.sel[0][psr_pkg::OD_BIT]);
    cov_lock_two_latch: cover property (cur.lockLatch[1] ##1 !cur.lockLatch[1]);

endmodule

/* bench/psr_board.sv */
`timescale 1ns/10ps
// The board holds every released pad at its own level, so an undriven pin never
// reads back a stale device value.
module psr_board (
    input  wire logic [3:0] pinOut, // Device drive levels.
    input  wire logic [3:0] pinOe,  // Device drive enables.
    input  wire logic [3:0] ext,    // Board level of each pad.
    output logic      [3:0] pad     // Resolved pad levels.
);
    assign pad = (pinOe & pinOut) | (~pinOe & ext);
endmodule

/* bench/psr_tb_top.sv */
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin fail_count++; $display("CHECK FAILED %0t %s", $time, m); end end
module psr_tb_top;
    logic        clk_sys = 0, reset = 1, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, m1 = 0, m2 = 0, io = 0, own = 0, sw = 0;
    logic        awready, wready, bvalid, arready, rvalid, altSelect, irq;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0]  bresp, rresp, rs;
    logic [3:0]  pinIn, pinOut, pinOe, ext = 0;
    logic [2:0]  ls = 0;
    logic [39:0] bank = 0;
    logic [7:0]  lw = 0, role = 0;
    logic [7:0]  sel [4] = '{default: 8'h00};
    int          fail_count = 0, n_compared = 0;
    always #25 clk_sys = ~clk_sys;
    psr_top psr_top_i (.clk_sys(clk_sys), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .mult1LockRaw(m1), .mult2LockRaw(m2),
        .loopState(ls), .statusBank(bank), .irqOtherIn(io), .altSelect(altSelect), .irq(irq));
    psr_board psr_board_i (.pinOut(pinOut), .pinOe(pinOe), .ext(ext), .pad(pinIn));
    // ----------------------------------------------------------------------
    // Bus cycles and expectations
    // ----------------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic ta, tw, tb;
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(negedge clk_sys);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            rs = bresp;
            @(posedge clk_sys);
            if (ta) awvalid <= 0;
            if (tw) wvalid <= 0;
        end while (!tb);
        bready <= 0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
        logic ta, tr;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(negedge clk_sys);
            ta = arvalid & arready;
            tr = rvalid;
            rd = rdata;
            rs = rresp;
            @(posedge clk_sys);
            if (ta) arvalid <= 0;
        end while (!tr);
        rready <= 0;
        @(posedge clk_sys);
        `CHK({rs, rd}, {r, e}, "register read")
    endtask
    function automatic logic [1:0] ex(input logic [1:0] ro, input logic [7:0] s);
        logic v;
        case (s[5:3])
            psr_pkg::SRC_LOCK: v = lw[s[2:0]] & psr_pkg::LOCK_STATUS_MASK[s[2:0]];
            psr_pkg::SRC_LOOP: v = (ls == psr_pkg::LOOP_LOCKED);
            psr_pkg::SRC_IRQ:  v = io | own;
            default:           v = bank[{s[5:3], s[2:0]}];
        endcase
        if (ro != psr_pkg::ROLE_STAT) return ro;
        // A lock-register position that holds no status drives the pin low.
        if (s[5:3] == psr_pkg::SRC_LOCK && !psr_pkg::LOCK_STATUS_MASK[s[2:0]]) return 2'h2;
        return s[6] ? {v, ~s[7]} : {1'b1, v ^ s[7]};
    endfunction
    task automatic pins();
        logic [1:0] e;
        logic [3:0] pad;
        for (int i = 0; i < 4; i++) begin
            e = (i == 3 && sw) ? 2'h0 : ex(role[2*i+:2], sel[i]);
            `CHK({pinOe[i], pinOe[i] & pinOut[i]}, {e[1], &e}, "pin drive")
            pad[i] = e[1] ? e[0] : ext[i];
        end
        rc(12'h024, {28'h0, pad}, psr_pkg::RESP_OKAY);
    endtask
    task automatic end_of_test();
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        end_of_test();
    end
    initial begin
        void'($urandom(29));
        repeat (12) @(posedge clk_sys);
        reset <= 0;
        @(posedge clk_sys);
        for (int i = 7; i < 15; i++) rc(12'(4 * i), 32'h0, psr_pkg::RESP_OKAY);
        rc(12'h03C, 32'h0, psr_pkg::RESP_SLVERR);
        wr(12'h03C, 8'hFF);
        `CHK(rs, psr_pkg::RESP_SLVERR, "unmapped write")
        role = 8'h55;
        wr(12'h020, role);
        repeat (40) begin
            bank <= {8'($urandom), $urandom};
            ls <= 3'($urandom);
            io <= 1'($urandom);
            ext <= 4'($urandom);
            for (int i = 0; i < 4; i++) begin
                sel[i] = 8'($urandom);
                wr(12'(40 + 4 * i), sel[i]);
            end
            pins();
        end
        for (int r = 0; r < 4; r++) begin
            role = {4{2'(r)}};
            wr(12'h020, role);
            pins();
        end
        io <= 0;
        role = 8'h01;
        wr(12'h020, role);
        sel[0] = 8'h28;
        wr(12'h028, sel[0]);
        m1 <= 1;
        m2 <= 1;
        repeat (6) @(posedge clk_sys);
        lw = 8'h33;
        pins();
        rc(12'h01C, 32'h33, psr_pkg::RESP_OKAY);
        wr(12'h01C, 8'h04);
        lw = 8'h37;
        own = 1;
        `CHK(irq, 1'b1, "interrupt raised")
        sel[0] = 8'h38;
        wr(12'h028, sel[0]);
        pins();
        wr(12'h01C, 8'h26);
        lw = 8'h15;
        own = 0;
        `CHK(irq, 1'b0, "interrupt cleared")
        rc(12'h01C, 32'h15, psr_pkg::RESP_OKAY);
        sel[0] = 8'h2B;
        wr(12'h028, sel[0]);
        pins();
        role = 8'hC0;
        wr(12'h020, role);
        for (int k = 1; k < 4; k++) begin
            sw = 1;
            ext <= 4'h8;
            wr(12'h038, 8'(k));
            `CHK(altSelect, 1'b1, "alternate selection")
            ext <= 4'h0;
            repeat (4) @(posedge clk_sys);
            `CHK(altSelect, 1'b0, "primary selection")
            pins();
        end
        sw = 0;
        wr(12'h038, 8'h00);
        pins();
        end_of_test();
    end
endmodule
